// ---- bench/mbx_exec_tb_top.sv ----
module mbx_exec_tb_top
  import mbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // clock, reset and stimulus
  logic                      core_clk;
  logic                      rst;
  logic                      instr_valid;
  logic [OP_W-1:0]           instr_op;
  logic [ARG_W-1:0]          instr_arg;
  logic                      instr_dest;
  logic [FPAGE_N*DATA_W-1:0] fpage_regs;
  logic [FILE_AW-1:0]        peek_addr;
  // observed state
  logic [DATA_W-1:0]         peek_data;
  logic [PC_W-1:0]           pc;
  logic [DATA_W-1:0]         accumulator;
  logic                      zero_flag;
  logic [LVL_W-1:0]          stack_level;
  logic                      discard_fetch;
  // expected state, kept from the rules alone
  logic [PC_W-1:0]           exp_pc;
  logic [DATA_W-1:0]         exp_accum;
  logic                      exp_z;
  logic [LVL_W-1:0]          exp_lvl;
  logic [PC_W-1:0]           link_a;
  logic [PC_W-1:0]           link_b;
  int                        failures;
  int                        cmp_count;

  mbx_exec dut (
    .core_clk      (core_clk),
    .rst           (rst),
    .instr_valid   (instr_valid),
    .instr_op      (instr_op),
    .instr_arg     (instr_arg),
    .instr_dest    (instr_dest),
    .fpage_regs    (fpage_regs),
    .peek_addr     (peek_addr),
    .peek_data     (peek_data),
    .pc            (pc),
    .accumulator   (accumulator),
    .zero_flag     (zero_flag),
    .stack_level   (stack_level),
    .discard_fetch (discard_fetch)
  );

  // 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic compare(input logic [PC_W-1:0] got,
                         input logic [PC_W-1:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // whole core state against the expected copy
  task automatic chk_state(input logic disc);
    compare(pc, exp_pc, "pc");
    compare({2'b00, accumulator}, {2'b00, exp_accum}, "accumulator");
    compare({9'h000, zero_flag}, {9'h000, exp_z}, "zero flag");
    compare({6'h00, stack_level}, {6'h00, exp_lvl}, "stack level");
    compare({9'h000, discard_fetch}, {9'h000, disc}, "discard");
  endtask

  // one word taken at the next edge; hold leaves a stray load word on the
  // port so that a bubble has something to throw away
  task automatic issue(input logic [OP_W-1:0] op, input logic [ARG_W-1:0] arg,
                       input logic d, input logic hold);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_op    <= op;
    instr_arg   <= arg;
    instr_dest  <= d;
    @(posedge core_clk);
    instr_valid <= hold;
    instr_op    <= OP_LOAD_IMM;
    instr_arg   <= 10'h0ee;
    #1;
  endtask

  // bubble edge: stray word must be dropped and pc must hold the target
  task automatic bubble();
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    chk_state(1'b0);
  endtask

  task automatic t_nop();
    issue(OP_NOP, 10'h2aa, 1'b1, 1'b0);
    exp_pc = exp_pc + PC_STEP;
    chk_state(1'b0);
    issue(4'hf, 10'h155, 1'b1, 1'b0);
    exp_pc = exp_pc + PC_STEP;
    chk_state(1'b0);
    $display("test nop done");
  endtask

  task automatic t_imm(input logic [DATA_W-1:0] v);
    issue(OP_LOAD_IMM, {2'b00, v}, 1'b0, 1'b0);
    exp_pc  = exp_pc + PC_STEP;
    exp_accum = v;
    chk_state(1'b0);
    $display("test load immediate done");
  endtask

  // peek_addr sits on 63, so the top register is seen the edge it is written
  task automatic t_store();
    issue(OP_STORE_ACCUM, 10'h03f, 1'b0, 1'b0);
    exp_pc = exp_pc + PC_STEP;
    chk_state(1'b0);
    compare({2'b00, peek_data}, {2'b00, exp_accum}, "reg 63");
    issue(OP_STORE_ACCUM, 10'h000, 1'b0, 1'b0);
    exp_pc = exp_pc + PC_STEP;
    chk_state(1'b0);
    $display("test store done");
  endtask

  task automatic t_move(input logic [FILE_AW-1:0] r, input logic d,
                        input logic [DATA_W-1:0] val);
    issue(OP_MOVE_FILE, {4'h0, r}, d, 1'b0);
    exp_pc = exp_pc + PC_STEP;
    exp_z  = (val == 8'h00);
    if (!d) begin
      exp_accum = val;
    end
    chk_state(1'b0);
    compare({2'b00, peek_data}, 10'h0a5, "reg 63 kept");
    $display("test move done");
  endtask

  task automatic t_fpage(input logic [FPAGE_AW-1:0] f);
    issue(OP_READ_FPAGE, {6'h00, f}, 1'b0, 1'b0);
    exp_pc  = exp_pc + PC_STEP;
    exp_accum = 8'h30 + {4'h0, f};
    chk_state(1'b0);
    $display("test f-page read done");
  endtask

  task automatic t_jump(input logic [PC_W-1:0] t);
    issue(OP_LONG_JUMP, t, 1'b0, 1'b1);
    exp_pc = t;
    chk_state(1'b1);
    bubble();
    $display("test long jump done");
  endtask

  task automatic t_call(input logic [PC_W-1:0] t, output logic [PC_W-1:0] ra);
    ra = exp_pc + PC_STEP;
    issue(OP_LONG_CALL, t, 1'b1, 1'b1);
    exp_pc  = t;
    exp_lvl = exp_lvl + LVL_STEP;
    chk_state(1'b1);
    bubble();
    $display("test long call done");
  endtask

  task automatic t_return(input logic [PC_W-1:0] ra);
    issue(OP_SUB_RETURN, 10'h3c3, 1'b0, 1'b1);
    exp_pc  = ra;
    exp_lvl = exp_lvl - LVL_STEP;
    chk_state(1'b1);
    bubble();
    $display("test return done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang is cut short well past the expected fifty or so cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    failures    = 0;
    cmp_count   = 0;
    rst         = 1'b1;
    instr_valid = 1'b0;
    instr_op    = OP_NOP;
    instr_arg   = 10'h000;
    instr_dest  = 1'b0;
    peek_addr   = 6'h3f;
    for (int n = 0; n < FPAGE_N; n++) begin
      fpage_regs[8*n +: 8] = 8'h30 + 8'(n);
    end
    {exp_pc, exp_accum, exp_z, exp_lvl} =
      {PC_RST, ACCUM_RST, ZERO_RST, LVL_RST};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk_state(1'b0);
    compare({2'b00, peek_data}, 10'h000, "peek after reset");
    $display("test reset done");
    t_nop();
    t_imm(8'h00);
    t_imm(8'ha5);
    t_store();
    t_imm(8'h00);
    t_move(6'h00, 1'b0, 8'ha5);
    t_move(6'h05, 1'b1, 8'h00);
    t_move(6'h3f, 1'b1, 8'ha5);
    t_move(6'h05, 1'b0, 8'h00);
    t_fpage(4'hf);
    t_fpage(4'h0);
    t_jump(10'h3ff);
    t_nop();
    t_call(10'h2c0, link_a);
    t_call(10'h100, link_b);
    t_return(link_b);
    t_return(link_a);
    results();
  end

endmodule

// ---- core/mbx_exec.sv ----
// How it works
// RULE_01 - f-page read copies selected register 0..15 into accumulator, flags kept
// RULE_02 - long jump loads 10-bit target into pc, two cycles, no flags
// RULE_03 - long call pushes pc+1, raises stack level, loads target, two cycles
// RULE_04 - store copies accumulator into data register 0..63 in one cycle
// RULE_05 - immediate load puts 8-bit operand into accumulator, flags kept
// RULE_06 - no-operation only advances pc by one, single cycle
// RULE_07 - register move goes to accumulator when dest is 0, else itself
// RULE_08 - register move sets zero flag exactly when moved value is zero
// RULE_09 - return reloads pc from stack top, lowers level, two cycles
// RULE_10 - branches discard the fetched sequential word and run a bubble
module mbx_exec
  import mbx_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // decoded instruction from fetch
  input  wire logic                      instr_valid,
  input  wire logic [OP_W-1:0]           instr_op,
  input  wire logic [ARG_W-1:0]          instr_arg,
  input  wire logic                      instr_dest,
  // f-page special-function registers, register n at bits 8n+7..8n
  input  wire logic [FPAGE_N*DATA_W-1:0] fpage_regs,
  // data register observation
  input  wire logic [FILE_AW-1:0]        peek_addr,
  output logic      [DATA_W-1:0]         peek_data,
  // core state
  output logic      [PC_W-1:0]           pc,
  output logic      [DATA_W-1:0]         accumulator,
  output logic                           zero_flag,
  output logic      [LVL_W-1:0]          stack_level,
  output logic                           discard_fetch
);

  mbx_state_t        state;
  mbx_state_t        next_state;
  logic [PC_W-1:0]   next_pc;
  logic [DATA_W-1:0] next_accum;
  logic              next_zero;
  logic              next_discard;
  logic [DATA_W-1:0] next_peek;
  logic [DATA_W-1:0] file_mem [FILE_N];
  logic [DATA_W-1:0] next_file [FILE_N];
  logic              push;
  logic              pop;
  logic [PC_W-1:0]   return_addr;
  logic [PC_W-1:0]   stack_top;
  logic              take;
  logic [FILE_AW-1:0]  file_addr;
  logic [FPAGE_AW-1:0] fsel;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] fpage_val;
  logic [PC_W-1:0]   target;

  // return stack
  mbx_stack u_stack (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (push),
    .pop       (pop),
    .push_data (return_addr),
    .top       (stack_top),
    .level     (stack_level)
  );

  // operand fields; fetch presents the word that sits at pc
  always_comb begin
    take      = instr_valid && state == ST_EXEC;
    file_addr = instr_arg[FILE_AW-1:0];
    fsel      = instr_arg[FPAGE_AW-1:0];
    file_val  = file_mem[file_addr];
    fpage_val = fpage_regs[{fsel, 3'b000} +: DATA_W];
    target    = instr_arg[PC_W-1:0];
    return_addr = pc + PC_STEP;
  end

  // execute one instruction; unknown codes behave like a no-operation
  always_comb begin
    next_state = state;
    next_pc    = pc;
    next_accum = accumulator;
    next_zero  = zero_flag;
    next_file  = file_mem;
    push       = 1'b0;
    pop        = 1'b0;
    case (state)
      ST_EXEC: begin
        if (instr_valid) begin
          next_pc = return_addr; // RULE_06
          case (instr_op)
            OP_READ_FPAGE: begin
              next_accum = fpage_val; // RULE_01
            end
            OP_LONG_JUMP: begin
              next_pc    = target; // RULE_02
              next_state = ST_BUBBLE; // RULE_10
            end
            OP_LONG_CALL: begin
              push       = 1'b1; // RULE_03
              next_pc    = target; // RULE_03
              next_state = ST_BUBBLE; // RULE_10
            end
            OP_STORE_ACCUM: begin
              next_file[file_addr] = accumulator; // RULE_04
            end
            OP_LOAD_IMM: begin
              next_accum = instr_arg[DATA_W-1:0]; // RULE_05
            end
            OP_MOVE_FILE: begin
              // write-back onto itself keeps the value, only z changes
              if (instr_dest) begin
                next_file[file_addr] = file_val; // RULE_07
              end else begin
                next_accum = file_val; // RULE_07
              end
              next_zero = (file_val == ZERO_VAL); // RULE_08
            end
            OP_SUB_RETURN: begin
              pop        = 1'b1; // RULE_09
              next_pc    = stack_top; // RULE_09
              next_state = ST_BUBBLE; // RULE_10
            end
            default: begin
              next_pc = return_addr; // RULE_06
            end
          endcase
        end
      end
      ST_BUBBLE: begin
        // stale sequential word is dropped, pc already holds the target
        next_state = ST_EXEC; // RULE_10
      end
      default: begin
        next_state = ST_EXEC;
      end
    endcase
    next_discard = (next_state == ST_BUBBLE);
    next_peek    = next_file[peek_addr];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state         <= ST_EXEC;
      pc            <= PC_RST;
      accumulator   <= ACCUM_RST;
      zero_flag     <= ZERO_RST;
      discard_fetch <= 1'b0;
      peek_data     <= FILE_RST;
      file_mem      <= '{default: FILE_RST};
    end else begin
      state         <= next_state;
      pc            <= next_pc;
      accumulator   <= next_accum;
      zero_flag     <= next_zero;
      discard_fetch <= next_discard;
      peek_data     <= next_peek;
      file_mem      <= next_file;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_branch_taken;
    take && (instr_op == OP_LONG_JUMP || instr_op == OP_LONG_CALL ||
             instr_op == OP_SUB_RETURN);
  endsequence

  sequence s_bubble_then_exec;
    discard_fetch && state == ST_BUBBLE ##1 state == ST_EXEC;
  endsequence

  property p_read_fpage;
    take && instr_op == OP_READ_FPAGE |=>
      accumulator == $past(fpage_val) && $stable(zero_flag);
  endproperty
  a_read_fpage: assert property (p_read_fpage) // RULE_01
    else $error("f-page read did not reach accumulator");

  // target lands first, then the bubble edge must leave pc and z alone
  sequence s_jump_then_hold;
    pc == $past(target) ##1 pc == $past(pc, 1) && $stable(zero_flag);
  endsequence

  property p_long_jump;
    take && instr_op == OP_LONG_JUMP |=> s_jump_then_hold;
  endproperty
  a_long_jump: assert property (p_long_jump) // RULE_02
    else $error("long jump target or timing wrong");

  property p_long_call;
    take && instr_op == OP_LONG_CALL && stack_level != LVL_FULL |=>
      stack_level == $past(stack_level) + LVL_STEP &&
      stack_top == $past(return_addr) && pc == $past(target);
  endproperty
  a_long_call: assert property (p_long_call) // RULE_03
    else $error("long call push or target wrong");

  property p_store;
    take && instr_op == OP_STORE_ACCUM && peek_addr == file_addr |=>
      peek_data == $past(accumulator) && $stable(accumulator);
  endproperty
  a_store: assert property (p_store) // RULE_04
    else $error("accumulator store lost");

  property p_load_imm;
    take && instr_op == OP_LOAD_IMM |=>
      accumulator == $past(instr_arg[DATA_W-1:0]) && $stable(zero_flag);
  endproperty
  a_load_imm: assert property (p_load_imm) // RULE_05
    else $error("immediate load wrong");

  property p_nop;
    take && instr_op == OP_NOP |=>
      pc == $past(return_addr) && $stable(accumulator) && $stable(zero_flag);
  endproperty
  a_nop: assert property (p_nop) // RULE_06
    else $error("no-operation changed state");

  property p_move_acc;
    take && instr_op == OP_MOVE_FILE && !instr_dest |=>
      accumulator == $past(file_val);
  endproperty
  a_move_acc: assert property (p_move_acc) // RULE_07
    else $error("register move to accumulator wrong");

  property p_move_zero;
    take && instr_op == OP_MOVE_FILE |=>
      zero_flag == ($past(file_val) == ZERO_VAL);
  endproperty
  a_move_zero: assert property (p_move_zero) // RULE_08
    else $error("zero flag wrong after register move");

  property p_return;
    take && instr_op == OP_SUB_RETURN && stack_level != LVL_RST |=>
      pc == $past(stack_top) &&
      stack_level == $past(stack_level) - LVL_STEP;
  endproperty
  a_return: assert property (p_return) // RULE_09
    else $error("return did not restore pc");

  property p_bubble;
    s_branch_taken |=> s_bubble_then_exec;
  endproperty
  a_bubble: assert property (p_bubble) // RULE_10
    else $error("branch bubble missing or too long");

  property p_bubble_quiet;
    state == ST_BUBBLE |=> $stable(pc) && $stable(accumulator);
  endproperty
  a_bubble_quiet: assert property (p_bubble_quiet) // RULE_10
    else $error("discarded word changed state");

endmodule

// ---- core/mbx_pkg.sv ----
package mbx_pkg;

  // widths
  localparam int PC_W     = 10;
  localparam int DATA_W   = 8;
  localparam int OP_W     = 4;
  localparam int ARG_W    = 10;
  localparam int FILE_N   = 64;
  localparam int FILE_AW  = 6;
  localparam int FPAGE_N  = 16;
  localparam int FPAGE_AW = 4;
  localparam int STACK_N  = 8;
  localparam int SP_W     = 3;
  localparam int LVL_W    = 4;

  // reset values
  localparam logic [PC_W-1:0]   PC_RST   = 10'h000;
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
  localparam logic              ZERO_RST = 1'b0;
  localparam logic [LVL_W-1:0]  LVL_RST  = 4'h0;

  // increments and limits
  localparam logic [PC_W-1:0]   PC_STEP  = 10'h001;
  localparam logic [LVL_W-1:0]  LVL_STEP = 4'h1;
  localparam logic [LVL_W-1:0]  LVL_FULL = 4'h8;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;

  // decoded operation codes presented by fetch/decode
  localparam logic [OP_W-1:0] OP_NOP         = 4'h0;
  localparam logic [OP_W-1:0] OP_READ_FPAGE  = 4'h1;
  localparam logic [OP_W-1:0] OP_LONG_JUMP   = 4'h2;
  localparam logic [OP_W-1:0] OP_LONG_CALL   = 4'h3;
  localparam logic [OP_W-1:0] OP_STORE_ACCUM = 4'h4;
  localparam logic [OP_W-1:0] OP_LOAD_IMM    = 4'h5;
  localparam logic [OP_W-1:0] OP_MOVE_FILE   = 4'h6;
  localparam logic [OP_W-1:0] OP_SUB_RETURN  = 4'h7;

  // execute sequencer
  typedef enum logic [1:0] {
    ST_EXEC   = 2'b01,
    ST_BUBBLE = 2'b10
  } mbx_state_t;

endpackage

// ---- core/mbx_stack.sv ----
module mbx_stack
  import mbx_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // push and pop requests
  input  wire logic              push,
  input  wire logic              pop,
  input  wire logic [PC_W-1:0]   push_data,
  // stack state
  output logic      [PC_W-1:0]   top,
  output logic      [LVL_W-1:0]  level
);

  logic [PC_W-1:0]  mem [STACK_N];
  logic [PC_W-1:0]  next_mem [STACK_N];
  logic [LVL_W-1:0] next_level;
  logic [SP_W-1:0]  top_idx;

  // top entry sits one below the level; empty stack reads entry 0
  always_comb begin
    top_idx = (level == LVL_RST) ? '0 : SP_W'(level - LVL_STEP);
    top     = mem[top_idx];
  end

  // full stack overwrites its top entry instead of wrapping
  always_comb begin
    next_mem   = mem;
    next_level = level;
    if (push) begin
      if (level == LVL_FULL) begin
        next_mem[top_idx] = push_data;
      end else begin
        next_mem[SP_W'(level)] = push_data;
        next_level             = level + LVL_STEP;
      end
    end else if (pop && level != LVL_RST) begin
      next_level = level - LVL_STEP;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem   <= '{default: PC_RST};
      level <= LVL_RST;
    end else begin
      mem   <= next_mem;
      level <= next_level;
    end
  end

endmodule
